// ===== rtr_nv_model.sv
// Nonvolatile image and thermometer beside the register pages
`timescale 1ns/1ps
module rtr_nv_model #(
    parameter logic [7:0] CFG_INIT  = 8'h02,
    parameter logic [7:0] XOFS_INIT = 8'hf9,
    parameter int         MEAS_DLY  = 20
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Thermometer
    input  wire logic       meas_req,
    input  wire logic [7:0] meas_src,
    output logic            meas_valid,
    output logic      [7:0] meas_temp,
    // Nonvolatile image
    input  wire logic       nv_wr_stb,
    input  wire logic [7:0] nv_wr_addr,
    input  wire logic [7:0] nv_wr_data,
    output logic      [7:0] nv_config,
    output logic      [7:0] nv_xtal_ofs,
    output logic      [7:0] nv_user0,
    output logic      [7:0] nv_user1
);
    int cnt;
    // Image survives reset, like the real cells
    initial begin
        nv_config = CFG_INIT;
        nv_xtal_ofs = XOFS_INIT;
        nv_user0 = 8'h00;
        nv_user1 = 8'h00;
        meas_valid = 1'b0;
        meas_temp = 8'h00;
        cnt = 0;
    end
    always @(posedge clk) begin
        if (nv_wr_stb) begin
            case (nv_wr_addr)
                rtr_pkg::ADDR_CONFIG:   nv_config <= nv_wr_data;
                rtr_pkg::ADDR_XTAL_OFS: nv_xtal_ofs <= nv_wr_data;
                rtr_pkg::ADDR_USER0:    nv_user0 <= nv_wr_data;
                rtr_pkg::ADDR_USER1:    nv_user1 <= nv_wr_data;
                default: ;
            endcase
        end
        // Result line toggles when not valid
        meas_valid <= 1'b0;
        meas_temp <= ~meas_temp;
        if (sys_rst || !meas_req) begin
            cnt <= 0;
        end else if (cnt == MEAS_DLY) begin
            meas_valid <= 1'b1;
            meas_temp <= meas_src;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : rtr_nv_model

// ===== rtr_pkg.sv
// Register map, field layout, reset values and encodings of the register pages
package rtr_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_CNT_LO    = 8'h18;
    localparam logic [7:0] ADDR_CNT_HI    = 8'h19;
    localparam logic [7:0] ADDR_TEMP      = 8'h20;
    localparam logic [7:0] ADDR_USER0     = 8'h28;
    localparam logic [7:0] ADDR_USER1     = 8'h29;
    localparam logic [7:0] ADDR_CONFIG    = 8'h30;
    localparam logic [7:0] ADDR_XTAL_OFS  = 8'h31;

    // ****************************************
    // Reset values (before the nonvolatile load)
    // ****************************************
    localparam logic [7:0] RST_CNT_LO     = 8'h01;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_TEMP       = 8'h3c;

    // ****************************************
    // Control byte and crystal offset fields
    // ****************************************
    localparam int CFG_RES_LARGEST  = 7;
    localparam int CFG_RES_LARGE    = 6;
    localparam int CFG_RES_MID      = 5;
    localparam int CFG_RES_SMALL    = 4;
    localparam int CFG_FSEL_HI      = 3;
    localparam int CFG_FSEL_LO      = 2;
    localparam int CFG_THERM_EN     = 1;
    localparam int CFG_SCAN_SEL     = 0;
    localparam int XOFS_SIGN        = 7;

    // ****************************************
    // Temperature encoding and trim range
    // ****************************************
    localparam logic [7:0] TEMP_OFFSET    = 8'h3c;
    localparam logic [7:0] TEMP_MAX_CODE  = 8'hfa;
    localparam logic [6:0] XOFS_MAX_MAG   = 7'h79;

    // Load sequencer states
    typedef enum logic [1:0] {
        RTR_WAIT_SUPPLY,
        RTR_LOAD,
        RTR_MEASURE,
        RTR_RUN
    } rtr_state_t;

endpackage : rtr_pkg

// ===== rtr_regs.sv
// Timer, temperature, user nonvolatile and control register pages
`timescale 1ns/1ps

// Operation
// - Countdown reload is 16 bits: low byte at 18h, high at 19h.
// - High countdown byte holds any value 0 to 255.
// - Temperature code is degrees plus sixty, range 0 to 250; host writes are stored unclamped, up to 255.
// - Temperature value is frozen in a copy during a host access.
// - Host may write temperature only while thermometer is disabled.
// - Two user nonvolatile bytes at 28h and 29h, full byte range.
// - Control byte and crystal bytes live in nonvolatile memory.
// - Control bits 7..4 each connect one trickle-charge resistor.
// - Control bits 3..2 select clock output frequency code.
// - Bit 1 enables thermometer, bit 0 selects scan interval.
// - Crystal offset: bit 7 sign, bits 6..0 magnitude 0 to 121; host writes are stored unclamped, up to 127.
// - Crystal registers hold factory calibration for compensation.
// - At power-up with thermometer on, measure and compute compensation.
// - Load configuration from nonvolatile page once supply passes threshold.
module rtr_regs (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Host register access
    input  wire logic       acc_active,
    input  wire logic       wr_stb,
    input  wire logic [7:0] acc_addr,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    // Nonvolatile image and supply state
    input  wire logic       supply_ok_low2,
    input  wire logic [7:0] nv_config,
    input  wire logic [7:0] nv_xtal_ofs,
    input  wire logic [7:0] nv_user0,
    input  wire logic [7:0] nv_user1,
    output logic            nv_wr_stb,
    output logic      [7:0] nv_wr_addr,
    output logic      [7:0] nv_wr_data,
    // Thermometer
    input  wire logic       meas_valid,
    input  wire logic [7:0] meas_temp,
    output logic            meas_req,
    output logic            comp_calc_req,
    // Decoded controls
    output logic     [15:0] countdown_reload,
    output logic            trickle_res_largest_en,
    output logic            trickle_res_large_en,
    output logic            trickle_res_mid_en,
    output logic            trickle_res_small_en,
    output logic            clock_output_pin_freq_sel_hi,
    output logic            clock_output_pin_freq_sel_lo,
    output logic            therm_en,
    output logic            temp_scan_interval_sel,
    output logic            xtal_ofs_sign,
    output logic      [6:0] xtal_ofs_mag,
    output logic            config_loaded
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic supply_m_r, supply_s_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_m_r <= 1'b0;
            supply_s_r <= 1'b0;
        end else begin
            supply_m_r <= supply_ok_low2;
            supply_s_r <= supply_m_r;
        end
    end

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] cnt_lo_r, cnt_lo_nxt, cnt_hi_r, cnt_hi_nxt;
    logic [7:0] temp_r, temp_nxt, temp_hold_r, temp_hold_nxt;
    logic [7:0] user0_r, user0_nxt, user1_r, user1_nxt;
    logic [7:0] cfg_r, cfg_nxt, xofs_r, xofs_nxt;
    logic       acc_d_r, acc_d_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic       nvw_r, nvw_nxt;
    logic [7:0] nva_r, nva_nxt, nvd_r, nvd_nxt;
    logic       mreq_r, mreq_nxt, creq_r, creq_nxt, ld_r, ld_nxt;
    rtr_pkg::rtr_state_t st_r, st_nxt;

    function automatic logic is_nv(input logic [7:0] a);
        is_nv = (a == rtr_pkg::ADDR_USER0) || (a == rtr_pkg::ADDR_USER1)
             || (a == rtr_pkg::ADDR_CONFIG) || (a == rtr_pkg::ADDR_XTAL_OFS);
    endfunction : is_nv

    always_comb begin
        cnt_lo_nxt    = cnt_lo_r;
        cnt_hi_nxt    = cnt_hi_r;
        temp_nxt      = temp_r;
        temp_hold_nxt = temp_hold_r;
        user0_nxt     = user0_r;
        user1_nxt     = user1_r;
        cfg_nxt       = cfg_r;
        xofs_nxt      = xofs_r;
        st_nxt        = st_r;
        mreq_nxt      = 1'b0;
        creq_nxt      = 1'b0;
        ld_nxt        = ld_r;
        nvw_nxt       = 1'b0;
        nva_nxt       = nva_r;
        nvd_nxt       = nvd_r;
        acc_d_nxt     = acc_active;
        // Thermometer result updates live value
        if (meas_valid && cfg_r[rtr_pkg::CFG_THERM_EN]) begin
            temp_nxt = (meas_temp > rtr_pkg::TEMP_MAX_CODE)
                     ? rtr_pkg::TEMP_MAX_CODE : meas_temp;
        end
        // Snapshot at access start, hold through access
        if (!acc_active || !acc_d_r) begin
            temp_hold_nxt = temp_nxt;
        end
        case (st_r)
            rtr_pkg::RTR_WAIT_SUPPLY: begin
                if (supply_s_r) begin
                    st_nxt = rtr_pkg::RTR_LOAD;
                end
            end
            rtr_pkg::RTR_LOAD: begin
                cfg_nxt   = nv_config;
                xofs_nxt  = nv_xtal_ofs;
                user0_nxt = nv_user0;
                user1_nxt = nv_user1;
                ld_nxt    = 1'b1;
                st_nxt    = nv_config[rtr_pkg::CFG_THERM_EN]
                          ? rtr_pkg::RTR_MEASURE : rtr_pkg::RTR_RUN;
            end
            rtr_pkg::RTR_MEASURE: begin
                mreq_nxt = 1'b1;
                if (meas_valid) begin
                    mreq_nxt = 1'b0;
                    creq_nxt = 1'b1;
                    st_nxt   = rtr_pkg::RTR_RUN;
                end
            end
            rtr_pkg::RTR_RUN: begin
                st_nxt = rtr_pkg::RTR_RUN;
            end
            default: st_nxt = rtr_pkg::RTR_WAIT_SUPPLY;
        endcase
        // Host writes accepted once loaded
        if (wr_stb && ld_r) begin
            case (acc_addr)
                rtr_pkg::ADDR_CNT_LO: cnt_lo_nxt = wr_data;
                rtr_pkg::ADDR_CNT_HI: cnt_hi_nxt = wr_data;
                rtr_pkg::ADDR_TEMP: begin
                    if (!cfg_r[rtr_pkg::CFG_THERM_EN]) begin
                        temp_nxt      = wr_data;
                        temp_hold_nxt = wr_data;
                    end
                end
                rtr_pkg::ADDR_USER0:    user0_nxt = wr_data;
                rtr_pkg::ADDR_USER1:    user1_nxt = wr_data;
                rtr_pkg::ADDR_CONFIG:   cfg_nxt   = wr_data;
                rtr_pkg::ADDR_XTAL_OFS: xofs_nxt  = wr_data;
                default: ;
            endcase
            if (is_nv(acc_addr)) begin
                nvw_nxt = 1'b1;
                nva_nxt = acc_addr;
                nvd_nxt = wr_data;
            end
        end
        // Eight-bit read mux, unmapped reads zero
        case (acc_addr)
            rtr_pkg::ADDR_CNT_LO:   rd_nxt = cnt_lo_r;
            rtr_pkg::ADDR_CNT_HI:   rd_nxt = cnt_hi_r;
            rtr_pkg::ADDR_TEMP:     rd_nxt = temp_hold_r;
            rtr_pkg::ADDR_USER0:    rd_nxt = user0_r;
            rtr_pkg::ADDR_USER1:    rd_nxt = user1_r;
            rtr_pkg::ADDR_CONFIG:   rd_nxt = cfg_r;
            rtr_pkg::ADDR_XTAL_OFS: rd_nxt = xofs_r;
            default:                rd_nxt = rtr_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_lo_r    <= rtr_pkg::RST_CNT_LO;
            cnt_hi_r    <= rtr_pkg::RST_ZERO;
            temp_r      <= rtr_pkg::RST_TEMP;
            temp_hold_r <= rtr_pkg::RST_TEMP;
            user0_r     <= rtr_pkg::RST_ZERO;
            user1_r     <= rtr_pkg::RST_ZERO;
            cfg_r       <= rtr_pkg::RST_ZERO;
            xofs_r      <= rtr_pkg::RST_ZERO;
            st_r        <= rtr_pkg::RTR_WAIT_SUPPLY;
            mreq_r      <= 1'b0;
            creq_r      <= 1'b0;
            ld_r        <= 1'b0;
            nvw_r       <= 1'b0;
            nva_r       <= rtr_pkg::RST_ZERO;
            nvd_r       <= rtr_pkg::RST_ZERO;
            acc_d_r     <= 1'b0;
            rd_r        <= rtr_pkg::RST_ZERO;
        end else begin
            cnt_lo_r    <= cnt_lo_nxt;
            cnt_hi_r    <= cnt_hi_nxt;
            temp_r      <= temp_nxt;
            temp_hold_r <= temp_hold_nxt;
            user0_r     <= user0_nxt;
            user1_r     <= user1_nxt;
            cfg_r       <= cfg_nxt;
            xofs_r      <= xofs_nxt;
            st_r        <= st_nxt;
            mreq_r      <= mreq_nxt;
            creq_r      <= creq_nxt;
            ld_r        <= ld_nxt;
            nvw_r       <= nvw_nxt;
            nva_r       <= nva_nxt;
            nvd_r       <= nvd_nxt;
            acc_d_r     <= acc_d_nxt;
            rd_r        <= rd_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data                = rd_r;
    assign nv_wr_stb              = nvw_r;
    assign nv_wr_addr             = nva_r;
    assign nv_wr_data             = nvd_r;
    assign meas_req               = mreq_r;
    assign comp_calc_req          = creq_r;
    assign config_loaded          = ld_r;
    assign countdown_reload       = {cnt_hi_r, cnt_lo_r};
    assign trickle_res_largest_en = cfg_r[rtr_pkg::CFG_RES_LARGEST];
    assign trickle_res_large_en   = cfg_r[rtr_pkg::CFG_RES_LARGE];
    assign trickle_res_mid_en     = cfg_r[rtr_pkg::CFG_RES_MID];
    assign trickle_res_small_en   = cfg_r[rtr_pkg::CFG_RES_SMALL];
    assign clock_output_pin_freq_sel_hi     = cfg_r[rtr_pkg::CFG_FSEL_HI];
    assign clock_output_pin_freq_sel_lo     = cfg_r[rtr_pkg::CFG_FSEL_LO];
    assign therm_en               = cfg_r[rtr_pkg::CFG_THERM_EN];
    assign temp_scan_interval_sel = cfg_r[rtr_pkg::CFG_SCAN_SEL];
    assign xtal_ofs_sign          = xofs_r[rtr_pkg::XOFS_SIGN];
    assign xtal_ofs_mag           = xofs_r[6:0];

    // ****************************************
    // Checks
    // ****************************************
    a_reload_pair: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_stb && ld_r && acc_addr == rtr_pkg::ADDR_CNT_HI)
        |=> countdown_reload[15:8] == $past(wr_data))
        else $error("reload high byte not stored");
    a_temp_frozen: assert property (
        @(posedge clk) disable iff (sys_rst)
        (acc_active && $past(acc_active) && !wr_stb)
        |=> temp_hold_r == $past(temp_hold_r))
        else $error("temperature copy changed during access");
    a_temp_wr_block: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_stb && acc_addr == rtr_pkg::ADDR_TEMP && therm_en && !meas_valid)
        |=> temp_r == $past(temp_r))
        else $error("temperature written while thermometer on");
    a_temp_range: assert property (
        @(posedge clk) disable iff (sys_rst)
        therm_en |-> temp_r <= rtr_pkg::TEMP_MAX_CODE)
        else $error("temperature code above range");
    a_load_wait: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(config_loaded) |-> $past(supply_s_r, 2))
        else $error("config loaded before supply good");
    a_meas_powerup: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(config_loaded) && therm_en |-> ##[0:1] meas_req)
        else $error("no power-up measurement");
    a_nv_fwd: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_stb && ld_r && acc_addr == rtr_pkg::ADDR_CONFIG)
        |=> nv_wr_stb && nv_wr_data == $past(wr_data))
        else $error("config write not forwarded");
    a_unmapped_rd: assert property (
        @(posedge clk) disable iff (sys_rst)
        (acc_addr == 8'h00) |=> rd_data == rtr_pkg::RST_ZERO)
        else $error("unmapped address read nonzero");

endmodule : rtr_regs

// ===== rtr_regs_tb.sv
// Self-checking bench for the register pages
`timescale 1ns/1ps
module rtr_regs_tb;
    logic        clk, sys_rst, acc_active, wr_stb, supply_ok_low2;
    logic        meas_valid, meas_req, comp_calc_req, nv_wr_stb;
    logic        config_loaded, therm_en, xsign, r3, r2, r1, r0, fh, fl, sc;
    logic [7:0]  acc_addr, wr_data, rd_data, meas_src, meas_temp, d;
    logic [7:0]  nv_config, nv_xtal_ofs, nv_user0, nv_user1;
    logic [7:0]  nv_wr_addr, nv_wr_data, cfg_bits;
    logic [6:0]  xmag;
    logic [15:0] countdown_reload;
    int          n_fail, samples_checked, i;
    logic [7:0]  row_a [8] = '{8'h18, 8'h19, 8'h19, 8'h28, 8'h28, 8'h29,
                               8'h30, 8'h21};
    logic [7:0]  row_d [8] = '{8'ha5, 8'h00, 8'hff, 8'h00, 8'h3c, 8'hff,
                               8'hd9, 8'h55};
    logic [7:0]  row_e [8] = '{8'ha5, 8'h00, 8'hff, 8'h00, 8'h3c, 8'hff,
                               8'hd9, 8'h00};
    assign cfg_bits = {r3, r2, r1, r0, fh, fl, therm_en, sc};

    rtr_regs rtr_regs_inst (.clk(clk), .sys_rst(sys_rst),
        .acc_active(acc_active), .wr_stb(wr_stb), .acc_addr(acc_addr),
        .wr_data(wr_data), .rd_data(rd_data), .supply_ok_low2(supply_ok_low2),
        .nv_config(nv_config), .nv_xtal_ofs(nv_xtal_ofs), .nv_user0(nv_user0),
        .nv_user1(nv_user1), .nv_wr_stb(nv_wr_stb), .nv_wr_addr(nv_wr_addr),
        .nv_wr_data(nv_wr_data), .meas_valid(meas_valid),
        .meas_temp(meas_temp), .meas_req(meas_req),
        .comp_calc_req(comp_calc_req), .countdown_reload(countdown_reload),
        .trickle_res_largest_en(r3), .trickle_res_large_en(r2),
        .trickle_res_mid_en(r1), .trickle_res_small_en(r0),
        .clock_output_pin_freq_sel_hi(fh), .clock_output_pin_freq_sel_lo(fl),
        .therm_en(therm_en), .temp_scan_interval_sel(sc),
        .xtal_ofs_sign(xsign), .xtal_ofs_mag(xmag),
        .config_loaded(config_loaded));
    rtr_nv_model rtr_nv_model_inst (.clk(clk), .sys_rst(sys_rst),
        .meas_req(meas_req), .meas_src(meas_src), .meas_valid(meas_valid),
        .meas_temp(meas_temp), .nv_wr_stb(nv_wr_stb),
        .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data),
        .nv_config(nv_config), .nv_xtal_ofs(nv_xtal_ofs),
        .nv_user0(nv_user0), .nv_user1(nv_user1));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        acc_active = 1'b1;
        acc_addr = a;
        wr_data = v;
        wr_stb = 1'b1;
        @(posedge clk);
        #1;
        wr_stb = 1'b0;
        acc_active = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1;
        acc_active = 1'b1;
        acc_addr = a;
        repeat (2) @(posedge clk);
        #1;
        d = rd_data;
        acc_active = 1'b0;
    endtask : rd
    task automatic power_up;
        sys_rst = 1'b1;
        supply_ok_low2 = 1'b0;
        repeat (12) @(posedge clk);
        chk(countdown_reload, 16'h0001);
        #1 sys_rst = 1'b0;
        wr(rtr_pkg::ADDR_CNT_LO, 8'h77);
        supply_ok_low2 = 1'b1;
        for (i = 0; i < 50 && config_loaded !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(config_loaded, 16'h0001);
        chk(countdown_reload, 16'h0001);
    endtask : power_up
    task automatic wait_comp;
        for (i = 0; i < 100 && comp_calc_req !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(comp_calc_req, 16'h0001);
    endtask : wait_comp
    task automatic finish_test;
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100us;
        n_fail++;
        finish_test();
    end

    initial begin
        {acc_active, wr_stb, acc_addr, wr_data} = '0;
        n_fail = 0;
        samples_checked = 0;
        meas_src = 8'hff;
        power_up();
        chk(cfg_bits, 16'h0002);
        // Crystal offset is only read, never written
        chk({xsign, xmag}, 16'h00f9);
        wait_comp();
        rd(rtr_pkg::ADDR_TEMP);
        chk(d, rtr_pkg::TEMP_MAX_CODE);
        wr(rtr_pkg::ADDR_TEMP, 8'h11);
        rd(rtr_pkg::ADDR_TEMP);
        chk(d, rtr_pkg::TEMP_MAX_CODE);
        $display("test power_up done");
        for (int k = 0; k < 8; k++) begin
            wr(row_a[k], row_d[k]);
            rd(row_a[k]);
            chk(d, row_e[k]);
        end
        chk(countdown_reload, 16'hffa5);
        chk(cfg_bits, 16'h00d9);
        chk(nv_config, 16'h00d9);
        chk({nv_user1, nv_user0}, 16'hff3c);
        $display("test rows done");
        wr(rtr_pkg::ADDR_TEMP, 8'hc8);
        rd(rtr_pkg::ADDR_TEMP);
        chk(d, 16'h00c8);
        for (int fs = 0; fs < 4; fs++) begin
            wr(rtr_pkg::ADDR_CONFIG, {4'h5, fs[1:0], 2'b10});
            chk({fh, fl}, fs[1:0]);
        end
        chk(cfg_bits, 16'h005e);
        $display("test config done");
        meas_src = 8'h50;
        @(posedge clk);
        #1;
        power_up();
        acc_active = 1'b1;
        acc_addr = rtr_pkg::ADDR_TEMP;
        wait_comp();
        repeat (3) @(posedge clk);
        #1;
        chk(rd_data, rtr_pkg::RST_TEMP);
        acc_active = 1'b0;
        rd(rtr_pkg::ADDR_TEMP);
        chk(d, 16'h0050);
        chk(cfg_bits, 16'h005e);
        rd(rtr_pkg::ADDR_USER1);
        chk(d, 16'h00ff);
        $display("test retention done");
        finish_test();
    end
endmodule : rtr_regs_tb
